//--- ssao_top.sv
// Converter control: bit clock generation, successive approximation sequencing,
// serial shift-out and a result FIFO toward the host logic.
// Assumes comparator, pins and external clock are asynchronous to clk.
`timescale 1ns/10ps

// ---------------------------------------------------------------
// Result FIFO
// ---------------------------------------------------------------
module ssao_fifo #(
  parameter int unsigned WIDTH = 10,
  parameter int unsigned DEPTH = 32
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wr_ptr_ff;
  logic [AW-1:0]    rd_ptr_ff;
  logic [AW:0]      count_ff;
  logic             push;
  logic             pop;

  // Handshakes are combinational from the fill level
  assign in_ready  = (count_ff != (AW+1)'(DEPTH));
  assign out_valid = (count_ff != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_ff[rd_ptr_ff];

  // Storage is written only on a push
  always_ff @(posedge clk)
  begin
    if (push)
      mem_ff[wr_ptr_ff] <= in_data;
  end

  // Pointers and fill level
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH-1)) ? '0 : wr_ptr_ff + 1'b1;
      if (pop)
        rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH-1)) ? '0 : rd_ptr_ff + 1'b1;
      if (push && !pop)
        count_ff <= count_ff + 1'b1;
      else if (pop && !push)
        count_ff <= count_ff - 1'b1;
    end
  end
endmodule : ssao_fifo

// ---------------------------------------------------------------
// Converter control top
// ---------------------------------------------------------------
module ssao_top (
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire logic                      convert_request,
  input  wire logic                      clock_hold_input,
  input  wire logic                      ext_clock_in,
  input  wire logic                      use_ext_clock,
  input  wire logic [2:0]                early_stop_input,
  input  wire logic                      comparator_in,
  output logic                           bit_clock_out,
  output logic                           data_out,
  output logic                           busy,
  output logic [ssao_pkg::RES_W-1:0]     dac_code,
  output logic                           ext_rate_error,
  output logic                           result_valid,
  input  wire logic                      result_ready,
  output logic [ssao_pkg::RES_W-1:0]     result_data
);

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  logic [1:0] convert_request_sync_ff;
  logic [1:0] hold_sync_ff;
  logic [2:0] xcl_sync_ff;    // Third stage only feeds edge detection
  logic [1:0] sel_sync_ff;
  logic [1:0] cmp_sync_ff;
  logic [2:0] stop_s1_ff;
  logic [2:0] stop_s2_ff;
  logic       convert_request_prev_ff;

  // Two flops before any logic looks at a pin
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      convert_request_sync_ff <= 2'h0;
      hold_sync_ff <= 2'h0;
      xcl_sync_ff  <= 3'h0;
      sel_sync_ff  <= 2'h0;
      cmp_sync_ff  <= 2'h0;
      stop_s1_ff   <= 3'h0;
      stop_s2_ff   <= 3'h0;
      convert_request_prev_ff <= 1'b0;
    end
    else
    begin
      convert_request_sync_ff <= {convert_request_sync_ff[0], convert_request};
      hold_sync_ff <= {hold_sync_ff[0], clock_hold_input};
      xcl_sync_ff  <= {xcl_sync_ff[1:0], ext_clock_in};
      sel_sync_ff  <= {sel_sync_ff[0], use_ext_clock};
      cmp_sync_ff  <= {cmp_sync_ff[0], comparator_in};
      stop_s1_ff   <= early_stop_input;
      stop_s2_ff   <= stop_s1_ff;
      convert_request_prev_ff <= convert_request_sync_ff[1];
    end
  end

  logic convert_request_rise;
  logic hold;
  logic xcl_rise;
  logic xcl_fall;
  assign convert_request_rise = convert_request_sync_ff[1] && !convert_request_prev_ff;
  assign hold      = hold_sync_ff[1];
  assign xcl_rise  = xcl_sync_ff[1] && !xcl_sync_ff[2];
  assign xcl_fall  = !xcl_sync_ff[1] && xcl_sync_ff[2];

  // ---------------------------------------------------------------
  // Bit clock sources
  // ---------------------------------------------------------------
  logic [ssao_pkg::DIV_W-1:0] div_ff;
  logic                       int_phase_ff;
  logic                       int_tick;
  logic                       rise_evt;
  logic                       fall_evt;

  assign int_tick = (div_ff == ssao_pkg::INT_HALF_CYC - 1'b1);

  // Free-running internal divider; phase high = first half of a cycle
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      div_ff       <= '0;
      int_phase_ff <= 1'b0;
    end
    else if (int_tick)
    begin
      div_ff       <= '0;
      int_phase_ff <= !int_phase_ff;
    end
    else
      div_ff <= div_ff + 1'b1;
  end

  // Clock select; hold masks both edges so the sequence freezes
  assign rise_evt = !hold && (sel_sync_ff[1] ? xcl_rise
                                             : int_tick && !int_phase_ff);
  assign fall_evt = !hold && (sel_sync_ff[1] ? xcl_fall
                                             : int_tick && int_phase_ff);

  // ---------------------------------------------------------------
  // External clock rate check
  // ---------------------------------------------------------------
  logic [ssao_pkg::DIV_W-1:0] xper_ff;

  // Period between external rises, saturating; flag a too-fast clock
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      xper_ff        <= '0;
      ext_rate_error <= 1'b0;
    end
    else if (xcl_rise)
    begin
      xper_ff        <= '0;
      ext_rate_error <= sel_sync_ff[1] && (xper_ff < ssao_pkg::EXT_MIN_CYC);
    end
    else if (xper_ff != '1)
      xper_ff <= xper_ff + 1'b1;
  end

  // ---------------------------------------------------------------
  // Conversion sequence
  // ---------------------------------------------------------------
  function automatic logic [ssao_pkg::CYC_W-1:0] cycles_for(input logic [2:0] sel);
    case (sel)
      ssao_pkg::STOP_2: cycles_for = 4'h3;
      ssao_pkg::STOP_4: cycles_for = 4'h5;
      ssao_pkg::STOP_6: cycles_for = 4'h7;
      ssao_pkg::STOP_8: cycles_for = 4'h9;
      default:          cycles_for = ssao_pkg::FULL_CYCLES;
    endcase
  endfunction : cycles_for

  ssao_pkg::ssao_state_t      state_ff;
  logic [ssao_pkg::CYC_W-1:0] cyc_ff;       // Index of the current bit cycle
  logic [ssao_pkg::CYC_W-1:0] ncyc_ff;      // Cycles in this conversion
  logic                       started_ff;   // First rise of the frame seen
  logic                       pend_ff;      // Request caught during last cycle
  logic [ssao_pkg::RES_W-1:0] trial_ff;
  logic                       fifo_ready;
  logic                       start;
  logic                       last_cyc;

  assign last_cyc = (cyc_ff == ncyc_ff - 1'b1);
  // Back-pressure: no new conversion while the FIFO has no room
  assign start = (state_ff == ssao_pkg::SSAO_IDLE) && fifo_ready &&
                 (convert_request_rise || pend_ff);

  // Sequence state and cycle count
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_ff   <= ssao_pkg::SSAO_IDLE;
      cyc_ff     <= '0;
      ncyc_ff    <= ssao_pkg::FULL_CYCLES;
      started_ff <= 1'b0;
    end
    else
    begin
      case (state_ff)
        ssao_pkg::SSAO_IDLE:
        begin
          if (start)
          begin
            state_ff   <= ssao_pkg::SSAO_RUN;
            cyc_ff     <= '0;
            started_ff <= 1'b0;
            ncyc_ff    <= cycles_for(stop_s2_ff);
          end
        end
        ssao_pkg::SSAO_RUN:
        begin
          if (rise_evt && started_ff)
            cyc_ff <= cyc_ff + 1'b1;
          if (rise_evt)
            started_ff <= 1'b1;
          if (fall_evt && started_ff && last_cyc)
            state_ff <= ssao_pkg::SSAO_DONE;
        end
        ssao_pkg::SSAO_DONE:
          state_ff <= ssao_pkg::SSAO_IDLE;
        default:
          state_ff <= ssao_pkg::SSAO_IDLE;
      endcase
    end
  end

  // A request while busy is low in the last cycle is kept, not lost
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      pend_ff <= 1'b0;
    else if (start)
      pend_ff <= 1'b0;
    else if (convert_request_rise && !busy)
      pend_ff <= 1'b1;
  end

  // Busy: up at start, down at the rise opening the last cycle
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      busy <= 1'b0;
    else if (start)
      busy <= 1'b1;
    else if (state_ff == ssao_pkg::SSAO_RUN && rise_evt && started_ff &&
             (cyc_ff + 1'b1 == ncyc_ff - 1'b1))
      busy <= 1'b0;
    else if (state_ff == ssao_pkg::SSAO_RUN && rise_evt && !started_ff &&
             ncyc_ff == 4'h1)
      busy <= 1'b0;
  end

  // Bit clock output follows the selected clock only inside a frame
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      bit_clock_out <= 1'b0;
    else if (state_ff == ssao_pkg::SSAO_RUN && rise_evt)
      bit_clock_out <= 1'b1;
    else if (fall_evt || state_ff != ssao_pkg::SSAO_RUN)
      bit_clock_out <= 1'b0;
  end

  // ---------------------------------------------------------------
  // Successive approximation and serial data
  // ---------------------------------------------------------------
  logic [ssao_pkg::RES_W-1:0] sar_ff;
  logic                       decide;
  logic                       bit_val;

  // Each rise after the lead cycle settles one bit, MSB first
  assign decide  = state_ff == ssao_pkg::SSAO_RUN && rise_evt && started_ff;
  // Comparator high means input at or above trial; bipolar offset keeps
  // the code in offset binary without any conversion here
  assign bit_val = cmp_sync_ff[1];

  // Trial word drives the internal DAC
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sar_ff   <= ssao_pkg::SAR_RST;
      trial_ff <= ssao_pkg::TRIAL_MSB;
    end
    else if (start)
    begin
      sar_ff   <= ssao_pkg::SAR_RST;
      trial_ff <= ssao_pkg::TRIAL_MSB;
    end
    else if (decide)
    begin
      if (bit_val)
        sar_ff <= sar_ff | trial_ff;
      trial_ff <= trial_ff >> 1;
    end
  end

  assign dac_code = sar_ff | trial_ff;

  // Data pin changes only on a bit clock rise, steady through its fall;
  // the lead cycle keeps the previous bit so the pin never moves off a rise
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      data_out <= 1'b0;
    else if (decide)
      data_out <= bit_val;
  end

  // ---------------------------------------------------------------
  // Result buffering
  // ---------------------------------------------------------------
  logic push;
  assign push = (state_ff == ssao_pkg::SSAO_DONE);

  // Truncated results stay left aligned, lower bits zero
  ssao_fifo #(
    .WIDTH (ssao_pkg::RES_W),
    .DEPTH (ssao_pkg::FIFO_D)
  ) u_fifo (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (push),
    .in_ready  (fifo_ready),
    .in_data   (sar_ff),
    .out_valid (result_valid),
    .out_ready (result_ready),
    .out_data  (result_data)
  );

endmodule : ssao_top

//--- ssao_pkg.sv
// Constants for the serial successive-approximation converter control block.
// Assumes a single 100 MHz system clock; all link pins arrive unsynchronised.
package ssao_pkg;

  // ---------------------------------------------------------------
  // Widths and FIFO depth
  // ---------------------------------------------------------------
  localparam int unsigned RES_W   = 10;
  localparam int unsigned CYC_W   = 4;
  localparam int unsigned DIV_W   = 12;
  localparam int unsigned FIFO_D  = 32;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned SYS_CLK_HZ   = 100_000_000;
  localparam int unsigned INT_CLK_HZ   = 400_000;   // Internal bit clock rate
  localparam int unsigned EXT_MAX_HZ   = 450_000;   // Fastest legal external clock
  localparam logic [DIV_W-1:0] INT_HALF_CYC =
    DIV_W'(SYS_CLK_HZ / (2 * INT_CLK_HZ));
  // Least legal external period, rounded up to whole system cycles
  localparam logic [DIV_W-1:0] EXT_MIN_CYC =
    DIV_W'((SYS_CLK_HZ + EXT_MAX_HZ - 1) / EXT_MAX_HZ);

  // ---------------------------------------------------------------
  // Sequence lengths and reset values
  // ---------------------------------------------------------------
  localparam logic [CYC_W-1:0] FULL_CYCLES = 4'hb;  // 10 bits plus a lead cycle
  localparam logic [2:0] STOP_FULL = 3'h0;
  localparam logic [2:0] STOP_2    = 3'h1;
  localparam logic [2:0] STOP_4    = 3'h2;
  localparam logic [2:0] STOP_6    = 3'h3;
  localparam logic [2:0] STOP_8    = 3'h4;
  localparam logic [RES_W-1:0] SAR_RST   = 10'h000;
  localparam logic [RES_W-1:0] TRIAL_MSB = 10'h200;

  typedef enum logic [1:0] {SSAO_IDLE, SSAO_RUN, SSAO_DONE} ssao_state_t;

endpackage : ssao_pkg

//--- ssao_top_chk.sv
// Port assertions for ssao_top, bound in from the bench.
// Assumes one clock domain with async active-high reset.
`timescale 1ns/10ps
module ssao_top_chk (
  input wire logic                      clk,
  input wire logic                      rst,
  input wire logic                      convert_request,
  input wire logic                      clock_hold_input,
  input wire logic                      ext_clock_in,
  input wire logic                      use_ext_clock,
  input wire logic [2:0]                early_stop_input,
  input wire logic                      comparator_in,
  input wire logic                      bit_clock_out,
  input wire logic                      data_out,
  input wire logic                      busy,
  input wire logic [ssao_pkg::RES_W-1:0] dac_code,
  input wire logic                      ext_rate_error,
  input wire logic                      result_valid,
  input wire logic                      result_ready,
  input wire logic [ssao_pkg::RES_W-1:0] result_data
);
  logic [3:0] cnt_ff;
  logic [3:0] exp_ff;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Pulse count per frame; the last rise is not yet counted when busy falls
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_ff <= 4'h0;
      exp_ff <= 4'ha;
    end
    else if ($rose(busy))
    begin
      cnt_ff <= 4'h0;
      exp_ff <= (early_stop_input inside {[3'h1:3'h4]}) ? {early_stop_input, 1'b0} : 4'ha;
    end
    else if ($rose(bit_clock_out))
      cnt_ff <= cnt_ff + 4'h1;
  end
  property p_start; $rose(busy) |-> ##[1:400] $rose(bit_clock_out); endproperty
  a_start: assert property (p_start) else $error("no bit clock after start");
  property p_last; $fell(busy) |-> $rose(bit_clock_out); endproperty
  a_last: assert property (p_last) else $error("busy fell off cycle start");
  property p_step; $changed(data_out) |-> $rose(bit_clock_out); endproperty
  a_step: assert property (p_step) else $error("data moved off clock rise");
  property p_quiet; !busy && !bit_clock_out |=> !bit_clock_out; endproperty
  a_quiet: assert property (p_quiet) else $error("extra bit clock pulse");
  property p_count; $fell(busy) |-> cnt_ff == exp_ff; endproperty
  a_count: assert property (p_count) else $error("wrong pulse count");
  property p_hold; clock_hold_input [*5] |=> $stable(bit_clock_out) && $stable(busy); endproperty
  a_hold: assert property (p_hold) else $error("sequence ran during hold");
  property p_gap; $fell(busy) |=> !busy [*6]; endproperty
  a_gap: assert property (p_gap) else $error("busy back too soon");
  property p_push; $fell(busy) |-> ##[1:400] result_valid; endproperty
  a_push: assert property (p_push) else $error("result word missing");
  property p_head; result_valid && !result_ready |=> result_valid && $stable(result_data); endproperty
  a_head: assert property (p_head) else $error("head word lost");
endmodule : ssao_top_chk

//--- ssao_host_model.sv
// Host and analog side: external bit clock, comparator, serial capture.
// Assumes the bench gates the clock per frame and sets the input code.
`timescale 1ns/10ps
module ssao_host_model (
  input wire logic        clk,
  input wire logic        ext_run,
  input wire logic [9:0]  analog,
  input wire logic [9:0]  dac_code,
  input wire logic        bit_clock_out,
  input wire logic        data_out,
  input wire logic        busy,
  output logic            ext_clock_in,
  output logic            comparator_in,
  output logic [11:0]     cap_ff
);
  logic bco_d_ff;
  logic busy_d_ff;
  // Bipolar input held as offset binary, midscale meaning zero volts
  assign comparator_in = (analog >= dac_code);
  // Stands still low between frames; 6.25 MHz is over the limit on purpose
  initial
  begin
    ext_clock_in = 1'b0;
    forever
    begin
      #80;
      ext_clock_in = ext_run ? ~ext_clock_in : 1'b0;
    end
  end
  // Bit taken just after the falling bit clock, cleared at each start
  always_ff @(posedge clk)
  begin
    bco_d_ff  <= bit_clock_out;
    busy_d_ff <= busy;
    if (busy && !busy_d_ff)
      cap_ff <= 12'h000;
    else if (bco_d_ff && !bit_clock_out)
      cap_ff <= {cap_ff[10:0], data_out};
  end
endmodule : ssao_host_model

//--- serial_sar_adc_output_bench.sv
// Self-checking bench for ssao_top with the host model.
// Assumes a 100 MHz clk; host model supplies comparator and bit clock.
`timescale 1ns/10ps
module serial_sar_adc_output_bench;
  logic       clk = 1'b0, rst = 1'b1, convert_request = 1'b0, clock_hold_input = 1'b0;
  logic       use_ext_clock = 1'b0, result_ready = 1'b0, ext_run = 1'b0, snap;
  logic [2:0] early_stop_input = 3'h0;
  logic [9:0] analog = 10'h000, dac_code, result_data, snap_code;
  logic       ext_clock_in, comparator_in, bit_clock_out, data_out, busy;
  logic       ext_rate_error, result_valid;
  logic [11:0] cap;
  int         n_errors = 0, n_checks = 0, n_pops, i;
  // Rows: external clock, stop code, input code, expected left aligned word
  logic [23:0] rows [0:8] = '{24'h0a96a5, 24'h1fff00, 24'h255540, 24'h33c0f0,
    24'h400400, 24'h080200, 24'h570dc3, 24'h870dc3, 24'h9bfe00};
  ssao_top dut_u (.clk(clk), .rst(rst), .convert_request(convert_request),
    .clock_hold_input(clock_hold_input), .ext_clock_in(ext_clock_in),
    .use_ext_clock(use_ext_clock), .early_stop_input(early_stop_input),
    .comparator_in(comparator_in), .bit_clock_out(bit_clock_out), .data_out(data_out),
    .busy(busy), .dac_code(dac_code), .ext_rate_error(ext_rate_error),
    .result_valid(result_valid), .result_ready(result_ready), .result_data(result_data));
  ssao_host_model host_u (.clk(clk), .ext_run(ext_run), .analog(analog),
    .dac_code(dac_code), .bit_clock_out(bit_clock_out), .data_out(data_out),
    .busy(busy), .ext_clock_in(ext_clock_in), .comparator_in(comparator_in), .cap_ff(cap));
  always #5 clk = ~clk;
  task automatic step;
    @(posedge clk);
    #1;
  endtask : step
  task automatic check_flag(input string what, input logic exp, input logic got);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask : check_flag
  task automatic check_word(input string what, input logic [9:0] exp, input logic [9:0] got);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check_word
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : complete_run
  task automatic pulse_req;
    @(posedge clk);
    convert_request <= 1'b1;
    repeat (4) @(posedge clk);
    convert_request <= 1'b0;
  endtask : pulse_req
  task automatic pop;
    @(posedge clk);
    result_ready <= 1'b1;
    @(posedge clk);
    result_ready <= 1'b0;
  endtask : pop
  task automatic start_convert_request(input logic [23:0] r);
    int k;
    @(posedge clk);
    use_ext_clock    <= r[23];
    early_stop_input <= r[22:20];
    analog           <= r[19:10];
    ext_run          <= r[23];
    pulse_req();
    for (k = 0; k < 600 && busy !== 1'b1; k++)
      step();
    check_flag("busy at start", 1'b1, busy);
  endtask : start_convert_request
  // Last bit is only captured once the final bit clock has fallen
  task automatic wait_done;
    int k;
    for (k = 0; k < 5000 && busy === 1'b1; k++)
      step();
    for (k = 0; k < 400 && bit_clock_out === 1'b1; k++)
      step();
    for (k = 0; k < 400 && result_valid !== 1'b1; k++)
      step();
    step();
  endtask : wait_done
  task automatic end_convert_request(input logic [23:0] r);
    int bits;
    bits = (r[22:20] inside {[3'h1:3'h4]}) ? 2 * r[22:20] : 10;
    wait_done();
    check_word("result word", r[9:0], result_data);
    check_word("serial bits", r[9:0] >> (10 - bits), cap[9:0] & ~(10'h3ff << bits));
    ext_run <= 1'b0;
    pop();
  endtask : end_convert_request
  initial
  begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    step();
    check_word("reset code", 10'h200, dac_code);
    check_flag("reset flags", 1'b0, busy | bit_clock_out | data_out | result_valid);
    check_flag("reset rate flag", 1'b0, ext_rate_error);
    foreach (rows[r])
    begin
      start_convert_request(rows[r]);
      end_convert_request(rows[r]);
      $display("row %0d done", r);
    end
    step();
    check_flag("rate flag", 1'b1, ext_rate_error);
    // Hold mid-frame: bit clock and busy must freeze, result still exact
    start_convert_request(24'h0e9fa7);
    repeat (600) step();
    @(posedge clk);
    clock_hold_input <= 1'b1;
    repeat (6) step();
    snap = bit_clock_out;
    snap_code = dac_code;
    repeat (1000) step();
    check_flag("held bit clock", snap, bit_clock_out);
    check_flag("held busy", 1'b1, busy);
    check_word("held code", snap_code, dac_code);
    @(posedge clk);
    clock_hold_input <= 1'b0;
    end_convert_request(24'h0e9fa7);
    $display("hold test done");
    // Request inside the last cycle is kept and starts the next frame
    start_convert_request(rows[0]);
    for (i = 0; i < 5000 && busy === 1'b1; i++)
      step();
    start_convert_request(rows[0]);
    end_convert_request(rows[0]);
    step();
    check_flag("second word", 1'b1, result_valid);
    check_word("second value", rows[0][9:0], result_data);
    pop();
    $display("back to back done");
    // Fill the buffer, see the start held off, then drain everything
    for (i = 0; i < 32; i++)
    begin
      start_convert_request(rows[8]);
      wait_done();
    end
    pulse_req();
    repeat (100) step();
    check_flag("start while full", 1'b0, busy);
    @(posedge clk);
    result_ready <= 1'b1;
    n_pops = 0;
    repeat (600)
    begin
      n_pops += (result_valid === 1'b1);
      step();
    end
    @(posedge clk);
    result_ready <= 1'b0;
    ext_run <= 1'b0;
    check_word("words drained", 10'h021, n_pops[9:0]);
    step();
    check_flag("buffer empty", 1'b0, result_valid);
    $display("buffer test done");
    // Reset in mid frame: outputs idle at once, then a fresh frame converts
    start_convert_request(rows[0]);
    repeat (300) step();
    @(posedge clk);
    rst <= 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    step();
    check_flag("mid reset flags", 1'b0, busy | bit_clock_out | data_out | result_valid);
    check_flag("mid reset rate flag", 1'b0, ext_rate_error);
    check_word("mid reset code", 10'h200, dac_code);
    start_convert_request(rows[5]);
    end_convert_request(rows[5]);
    $display("mid reset test done");
    complete_run();
  end
  // About twice the expected run time of some 30,000 cycles
  initial
  begin
    #700000;
    n_errors++;
    $display("CHECK FAILED watchdog expected finish seen timeout");
    complete_run();
  end
endmodule : serial_sar_adc_output_bench
bind ssao_top ssao_top_chk chk_u (.clk(clk), .rst(rst), .convert_request(convert_request),
  .clock_hold_input(clock_hold_input), .ext_clock_in(ext_clock_in),
  .use_ext_clock(use_ext_clock), .early_stop_input(early_stop_input),
  .comparator_in(comparator_in), .bit_clock_out(bit_clock_out), .data_out(data_out),
  .busy(busy), .dac_code(dac_code), .ext_rate_error(ext_rate_error),
  .result_valid(result_valid), .result_ready(result_ready), .result_data(result_data));
